// *** test_upr_phy_resume_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module test_upr_phy_resume_ctrl;
	import upr_pkg::*;
	logic         sys_clk, resetn, psel, penable, pwrite;
	logic         pready, pslverr, suspended, irq, err;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd, w;
	logic [1:0]   line_req, ls_raw;
	upr_phy_out_t phy_out;
	upr_pwr_t     pwr_word;
	int           mismatches, samples_checked, seed;

	upr_phy_resume_ctrl #(.SUSP_CYC(20)) i_upr_phy_resume_ctrl (
		.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ls_raw(ls_raw), .phy_out(phy_out),
		.pwr_word(pwr_word), .suspended(suspended), .irq(irq)
	);

	upr_phy_line_model i_upr_phy_line_model (
		.sys_clk(sys_clk), .resetn(resetn),
		.line_req(line_req), .ls_raw(ls_raw)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
		// Flags cannot be set by software, bit 7 kept off by caller
		return v & 32'h0004_0F70;
	endfunction

	task automatic report_and_stop();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Slave latency is not assumed; watchdog bounds the wait
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		seed = 28;
		resetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		line_req = `UPR_LS_J;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		apb(1'b0, `UPR_OFF_PWR, 32'h0);
		chk(rd, `UPR_RST_WORD);
		apb(1'b0, `UPR_OFF_PHY, 32'h0);
		chk(rd, `UPR_RST_WORD);
		apb(1'b0, 12'h050, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 12'h050, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
			apb(1'b1, `UPR_OFF_PWR, w);
			apb(1'b0, `UPR_OFF_PWR, 32'h0);
			chk(rd, w & 32'h0000_01FF);
			chk({31'h0, err}, 32'h0);
			chk({23'h0, pwr_word}, w & 32'h0000_01FF);
			w = w & 32'hFFFF_FF7F;
			apb(1'b1, `UPR_OFF_PHY, w);
			apb(1'b0, `UPR_OFF_PHY, 32'h0);
			chk(rd, ctrl_exp(w));
			chk({27'h0, phy_out}, {27'h0, w[18], w[18], w[6:4]});
		end
		apb(1'b1, `UPR_OFF_PHY, 32'h0000_0300);
		apb(1'b1, `UPR_OFF_IRQ_ST, 32'h7);
		line_req <= `UPR_LS_K;
		repeat (6) @(posedge sys_clk);
		line_req <= `UPR_LS_J;
		repeat (30) @(posedge sys_clk);
		// Software polls the filtered state while bit 7 is clear
		apb(1'b0, `UPR_OFF_LS, 32'h0);
		chk(rd & 32'h3, {30'h0, `UPR_LS_J});
		line_req <= `UPR_LS_K;
		repeat (30) @(posedge sys_clk);
		apb(1'b0, `UPR_OFF_LS, 32'h0);
		chk(rd & 32'h1F, 32'h0000_000A);
		apb(1'b0, `UPR_OFF_IRQ_ST, 32'h0);
		chk(rd, 32'h4);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `UPR_OFF_IRQ_MSK, 32'h7);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `UPR_OFF_IRQ_ST, 32'h4);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `UPR_OFF_PHY, 32'h0000_0080);
			line_req <= `UPR_LS_J;
			repeat (40) @(posedge sys_clk);
			chk({31'h0, suspended}, 32'h1);
			line_req <= (k == 0) ? `UPR_LS_K : `UPR_LS_SE0;
			repeat (10) @(posedge sys_clk);
			chk({31'h0, suspended}, 32'h0);
			apb(1'b0, `UPR_OFF_PHY, 32'h0);
			chk(rd, (k == 0) ? 32'h0000_1080 : 32'h0000_2080);
			// Ones written to the flags must leave them set
			apb(1'b1, `UPR_OFF_PHY, 32'h0000_3080);
			apb(1'b0, `UPR_OFF_PHY, 32'h0);
			chk(rd, (k == 0) ? 32'h0000_1080 : 32'h0000_2080);
			apb(1'b0, `UPR_OFF_IRQ_ST, 32'h0);
			chk(rd & 32'h3, (k == 0) ? 32'h2 : 32'h1);
			chk({31'h0, irq}, 32'h1);
			apb(1'b1, `UPR_OFF_PHY, 32'h0000_0080);
			apb(1'b0, `UPR_OFF_PHY, 32'h0);
			chk(rd, 32'h0000_0080);
			apb(1'b1, `UPR_OFF_IRQ_ST, 32'h7);
		end
		report_and_stop();
	end
endmodule

`default_nettype wire

// *** upr_ls_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module upr_ls_filter #(
	parameter int CNT_W = `UPR_FLT_CNT_W
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Control
	input  wire logic [3:0] log2_cnt,
	// Linestate
	input  wire logic [1:0] ls_raw,
	output logic      [1:0] ls_filt,
	output logic            ls_chg
);
	localparam logic [CNT_W:0] ONE = (CNT_W+1)'(1);

	logic [1:0]     cand_q;
	logic [CNT_W:0] cnt_q;
	wire  [CNT_W:0] target   = ONE << log2_cnt;
	wire            raw_move = ls_raw != cand_q;
	wire            pending  = cand_q != ls_filt;
	wire            ripe     = cnt_q >= target;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cand_q  <= `UPR_LS_J;
			cnt_q   <= '0;
			ls_filt <= `UPR_LS_J;
			ls_chg  <= 1'b0;
		end else begin
			ls_chg <= 1'b0;
			if (raw_move) begin
				// Any bounce restarts the persistence window
				cand_q <= ls_raw;
				cnt_q  <= ONE;
			end else if (pending && ripe) begin
				ls_filt <= cand_q;
				ls_chg  <= 1'b1;
			end else if (pending) begin
				cnt_q <= cnt_q + ONE;
			end
		end
	end

	filt_persist_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ls_filt != $past(ls_filt)) |-> ($past(cnt_q) >= $past(target)))
		else $error("filtered linestate moved early");

	filt_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		raw_move |=> (cnt_q == ONE) && (cand_q == $past(ls_raw)))
		else $error("filter count not restarted");

	filt_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		ls_chg == (ls_filt != $past(ls_filt)))
		else $error("change pulse mismatch");

endmodule
`default_nettype wire

// *** upr_map.svh ***
`ifndef UPR_MAP_SVH
`define UPR_MAP_SVH

// Register byte offsets
`define UPR_OFF_PWR       12'h03C
`define UPR_OFF_PHY       12'h040
`define UPR_OFF_IRQ_ST    12'h044
`define UPR_OFF_IRQ_MSK   12'h048
`define UPR_OFF_LS        12'h04C

// Power signalling word fields
`define UPR_PWR_VALID     8
`define UPR_PWR_DATA_HI   7
`define UPR_PWR_DATA_LO   0

// PHY control fields
`define UPR_PHY_PD_DIS    18
`define UPR_PHY_RST_FLAG  13
`define UPR_PHY_RES_FLAG  12
`define UPR_PHY_FLT_HI    11
`define UPR_PHY_FLT_LO    8
`define UPR_PHY_SUSP_EN   7
`define UPR_PHY_CFG_HI    6
`define UPR_PHY_CFG_LO    4

// Interrupt status and mask layout
`define UPR_IRQ_RST       0
`define UPR_IRQ_RES       1
`define UPR_IRQ_LS        2
`define UPR_IRQ_W         3

// Linestate status fields
`define UPR_LS_FILT_HI    1
`define UPR_LS_FILT_LO    0
`define UPR_LS_RAW_HI     3
`define UPR_LS_RAW_LO     2
`define UPR_LS_SUSP       4

// Linestate codes
`define UPR_LS_SE0        2'h0
`define UPR_LS_J          2'h1
`define UPR_LS_K          2'h2

// Reset values
`define UPR_RST_WORD      32'h0000_0000
`define UPR_RST_FLT       4'h0
`define UPR_RST_CFG       3'h0
`define UPR_RST_PWR_DATA  8'h00
`define UPR_RST_IRQ       3'h0

// Timing
`define UPR_CLK_MHZ       100
`define UPR_SUSPEND_US    3000
`define UPR_FLT_CNT_W     16

`endif

// *** upr_phy_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module upr_phy_line_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Requested bus state
	input  wire logic [1:0] line_req,
	// Towards the block
	output logic      [1:0] ls_raw
);
	// Idle full-speed bus rests in J
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ls_raw <= `UPR_LS_J;
		end else begin
			ls_raw <= line_req;
		end
	end
endmodule

`default_nettype wire

// *** upr_phy_resume_ctrl.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

// Summary of operation
// - SE0 auto-resume sets reset-resume flag bit 13; software writes zero to clear.
// - K auto-resume sets resume flag bit 12; writing zero clears it.
// - Linestate change propagates after persisting two-to-the-field (bits 11:8) cycles.
// - Bit 7 enables hardware resume handling; otherwise software polls filtered linestate.
// - Bit 18 set disables pulldowns on both wide ports.
// - Bits 6:4 drive the three PHY configuration pins directly.
module upr_phy_resume_ctrl #(
	parameter int SUSP_CYC = `UPR_SUSPEND_US * `UPR_CLK_MHZ
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// PHY side
	input  wire logic [1:0]           ls_raw,
	output upr_pkg::upr_phy_out_t     phy_out,
	output upr_pkg::upr_pwr_t         pwr_word,
	// Status
	output logic                      suspended,
	output logic                      irq
);
	import upr_pkg::*;

	// Control and status state
	logic                  pd_dis_q;
	logic                  rst_flag_q;
	logic                  res_flag_q;
	logic [3:0]            flt_q;
	logic                  susp_en_q;
	logic [2:0]            cfg_q;
	logic                  pwr_valid_q;
	logic [7:0]            pwr_data_q;
	logic [`UPR_IRQ_W-1:0] irq_st_q;
	logic [`UPR_IRQ_W-1:0] irq_msk_q;
	logic                  susp_q;

	// Sub-block outputs
	logic [1:0] ls_filt;
	logic       ls_chg;
	logic       susp_raw;
	logic       rst_res_evt;
	logic       res_evt;

	upr_ls_filter #(
		.CNT_W (`UPR_FLT_CNT_W)
	) u_filt (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.log2_cnt (flt_q),
		.ls_raw   (ls_raw),
		.ls_filt  (ls_filt),
		.ls_chg   (ls_chg)
	);

	upr_susp_ctrl #(
		.SUSP_CYC (SUSP_CYC)
	) u_susp (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.enable     (susp_en_q),
		.ls_filt    (ls_filt),
		.suspended  (susp_raw),
		.rst_resume (rst_res_evt),
		.resume     (res_evt)
	);

	// APB decode: one wait state so read data and error come from flops
	wire acc_first = psel && penable && !pready;
	wire acc_done  = psel && penable && pready;
	wire wr_fire   = acc_done && pwrite && !pslverr;
	wire sel_pwr   = paddr == `UPR_OFF_PWR;
	wire sel_phy   = paddr == `UPR_OFF_PHY;
	wire sel_ist   = paddr == `UPR_OFF_IRQ_ST;
	wire sel_msk   = paddr == `UPR_OFF_IRQ_MSK;
	wire sel_ls    = paddr == `UPR_OFF_LS;
	wire mapped    = sel_pwr | sel_phy | sel_ist | sel_msk | sel_ls;
	wire wr_pwr    = wr_fire && sel_pwr;
	wire wr_phy    = wr_fire && sel_phy;
	wire wr_ist    = wr_fire && sel_ist;
	wire wr_msk    = wr_fire && sel_msk;

	// Read words
	wire [31:0] rd_pwr = {23'h0, pwr_valid_q, pwr_data_q};
	wire [31:0] rd_phy = {13'h0, pd_dis_q, 4'h0, rst_flag_q, res_flag_q,
	                      flt_q, susp_en_q, cfg_q, 4'h0};
	wire [31:0] rd_ist = {29'h0, irq_st_q};
	wire [31:0] rd_msk = {29'h0, irq_msk_q};
	wire [31:0] rd_ls  = {27'h0, susp_q, ls_raw, ls_filt};
	wire [31:0] rd_mux = sel_pwr ? rd_pwr :
	                     sel_phy ? rd_phy :
	                     sel_ist ? rd_ist :
	                     sel_msk ? rd_msk :
	                     sel_ls  ? rd_ls  : `UPR_RST_WORD;

	// Flags: a wake event in the clearing cycle wins over the clear
	wire rst_flag_d = rst_res_evt ||
	                  (wr_phy ? (rst_flag_q && pwdata[`UPR_PHY_RST_FLAG])
	                          : rst_flag_q);
	wire res_flag_d = res_evt ||
	                  (wr_phy ? (res_flag_q && pwdata[`UPR_PHY_RES_FLAG])
	                          : res_flag_q);

	wire [`UPR_IRQ_W-1:0] irq_evt = {ls_chg, res_evt, rst_res_evt};
	wire [`UPR_IRQ_W-1:0] irq_clr = wr_ist ? pwdata[`UPR_IRQ_W-1:0]
	                                       : `UPR_RST_IRQ;
	wire [`UPR_IRQ_W-1:0] irq_st_d = irq_evt | (irq_st_q & ~irq_clr);

	// APB answer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `UPR_RST_WORD;
		end else begin
			pready  <= acc_first;
			pslverr <= acc_first && !mapped;
			if (acc_first) begin
				prdata <= pwrite ? `UPR_RST_WORD : rd_mux;
			end
		end
	end

	// PHY control register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pd_dis_q   <= 1'b0;
			flt_q      <= `UPR_RST_FLT;
			susp_en_q  <= 1'b0;
			cfg_q      <= `UPR_RST_CFG;
		end else if (wr_phy) begin
			pd_dis_q  <= pwdata[`UPR_PHY_PD_DIS];
			flt_q     <= pwdata[`UPR_PHY_FLT_HI:`UPR_PHY_FLT_LO];
			susp_en_q <= pwdata[`UPR_PHY_SUSP_EN];
			cfg_q     <= pwdata[`UPR_PHY_CFG_HI:`UPR_PHY_CFG_LO];
		end
	end

	// Wake indication flags
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_flag_q <= 1'b0;
			res_flag_q <= 1'b0;
		end else begin
			rst_flag_q <= rst_flag_d;
			res_flag_q <= res_flag_d;
		end
	end

	// Power signalling word
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwr_valid_q <= 1'b0;
			pwr_data_q  <= `UPR_RST_PWR_DATA;
		end else if (wr_pwr) begin
			pwr_valid_q <= pwdata[`UPR_PWR_VALID];
			pwr_data_q  <= pwdata[`UPR_PWR_DATA_HI:`UPR_PWR_DATA_LO];
		end
	end

	// Interrupt status, mask and output
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_st_q  <= `UPR_RST_IRQ;
			irq_msk_q <= `UPR_RST_IRQ;
			irq       <= 1'b0;
			susp_q    <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			if (wr_msk) begin
				irq_msk_q <= pwdata[`UPR_IRQ_W-1:0];
			end
			// Registered: follows status and mask one cycle later
			irq    <= |(irq_st_q & irq_msk_q);
			susp_q <= susp_raw;
		end
	end

	assign suspended                = susp_q;
	// One driver per struct keeps each output a single net
	assign phy_out   = {pd_dis_q, pd_dis_q, cfg_q};
	assign pwr_word  = {pwr_valid_q, pwr_data_q};

	sequence s_apb_access;
		psel && penable && !pready;
	endsequence

	apb_one_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_apb_access |=> pready ##1 !pready)
		else $error("APB answer not after one wait state");

	rst_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		rst_res_evt |=> rst_flag_q && irq_st_q[`UPR_IRQ_RST])
		else $error("reset-resume flag lost");

	rst_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		rst_flag_q && !(wr_phy && !pwdata[`UPR_PHY_RST_FLAG]) |=> rst_flag_q)
		else $error("reset-resume flag dropped without a zero write");

	res_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		res_evt |=> res_flag_q && irq_st_q[`UPR_IRQ_RES])
		else $error("resume flag lost");

	res_flag_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_phy && !pwdata[`UPR_PHY_RES_FLAG] && !res_evt |=> !res_flag_q)
		else $error("resume flag not cleared by zero write");

	pulldown_ctl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_phy |=> phy_out.pulldown_dis_a == $past(pwdata[`UPR_PHY_PD_DIS])
		        && phy_out.pulldown_dis_b == phy_out.pulldown_dis_a)
		else $error("pulldown disable not following control bit");

	cfg_pins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_phy |=> phy_out.phy_config_pins ==
		           $past(pwdata[`UPR_PHY_CFG_HI:`UPR_PHY_CFG_LO]))
		else $error("config pins not following control field");

	irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		|(irq_st_q & irq_msk_q) |=> irq)
		else $error("interrupt not raised for unmasked status");

	no_hw_susp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!susp_en_q [*2] |=> !suspended)
		else $error("suspended while hardware control disabled");

	rst_flag_clr_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_phy && !pwdata[`UPR_PHY_RST_FLAG] && !rst_res_evt |=> !rst_flag_q)
		else $error("reset-resume flag not cleared by zero write");

	res_flag_hold_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		res_flag_q && !(wr_phy && !pwdata[`UPR_PHY_RES_FLAG]) |=> res_flag_q)
		else $error("resume flag dropped without a zero write");

	rst_flag_sw_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!rst_flag_q && !rst_res_evt |=> !rst_flag_q)
		else $error("reset-resume flag set without a wake event");

	res_flag_sw_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!res_flag_q && !res_evt |=> !res_flag_q)
		else $error("resume flag set without a wake event");

	wake_kind_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!(rst_res_evt && res_evt))
		else $error("both wake kinds flagged at once");

	filt_field_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_phy |=> flt_q == $past(pwdata[`UPR_PHY_FLT_HI:`UPR_PHY_FLT_LO]))
		else $error("filter length not taken from control field");

	lschg_status_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		ls_chg |=> irq_st_q[`UPR_IRQ_LS])
		else $error("linestate change not recorded in status");

	susp_en_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_phy |=> susp_en_q == $past(pwdata[`UPR_PHY_SUSP_EN]))
		else $error("suspend enable not taken from control bit");

	susp_follow_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		suspended == $past(susp_raw))
		else $error("suspended output not one cycle behind controller");

	irq_low_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!(|(irq_st_q & irq_msk_q)) |=> !irq)
		else $error("interrupt raised with nothing unmasked pending");

	ist_keep_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		irq_st_q[`UPR_IRQ_LS] && !(wr_ist && pwdata[`UPR_IRQ_LS])
		|=> irq_st_q[`UPR_IRQ_LS])
		else $error("status bit dropped without a one write");

	ist_clr_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_ist && pwdata[`UPR_IRQ_RST] && !rst_res_evt
		|=> !irq_st_q[`UPR_IRQ_RST])
		else $error("status bit not cleared by one write");

	msk_wr_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_msk |=> irq_msk_q == $past(pwdata[`UPR_IRQ_W-1:0]))
		else $error("mask not following write");

	apb_err_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_apb_access && !mapped |=> pready && pslverr)
		else $error("unmapped access not refused");

	apb_ok_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_apb_access && mapped |=> pready && !pslverr)
		else $error("mapped access refused");

	apb_wr_zero_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_apb_access && pwrite |=> prdata == `UPR_RST_WORD)
		else $error("read data not zero on a write");

	pwr_word_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		wr_pwr |=> pwr_word == $past(pwdata[`UPR_PWR_VALID:`UPR_PWR_DATA_LO]))
		else $error("power word not following write");

endmodule
`default_nettype wire

// *** upr_pkg.sv ***
package upr_pkg;

	typedef struct packed {
		logic       pulldown_dis_a;
		logic       pulldown_dis_b;
		logic [2:0] phy_config_pins;
	} upr_phy_out_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} upr_pwr_t;

	typedef enum logic {
		upr_st_awake,
		upr_st_susp
	} upr_susp_st_t;

endpackage

// *** upr_susp_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.svh"

module upr_susp_ctrl #(
	parameter int SUSP_CYC = `UPR_SUSPEND_US * `UPR_CLK_MHZ
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Control
	input  wire logic       enable,
	input  wire logic [1:0] ls_filt,
	// Status
	output logic            suspended,
	output logic            rst_resume,
	output logic            resume
);
	import upr_pkg::*;

	localparam int            CW    = $clog2(SUSP_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(SUSP_CYC - 1);
	localparam logic [CW-1:0] C_ONE = CW'(1);

	upr_susp_st_t  st_q;
	logic [CW-1:0] cnt_q;
	wire           idle_j = enable && (ls_filt == `UPR_LS_J);
	wire           is_se0 = ls_filt == `UPR_LS_SE0;
	wire           is_k   = ls_filt == `UPR_LS_K;

	assign suspended = st_q == upr_st_susp;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q       <= upr_st_awake;
			cnt_q      <= '0;
			rst_resume <= 1'b0;
			resume     <= 1'b0;
		end else begin
			rst_resume <= 1'b0;
			resume     <= 1'b0;
			unique case (st_q)
				upr_st_awake: begin
					if (!idle_j) begin
						cnt_q <= '0;
					end else if (cnt_q == LIMIT) begin
						cnt_q <= '0;
						st_q  <= upr_st_susp;
					end else begin
						cnt_q <= cnt_q + C_ONE;
					end
				end
				upr_st_susp: begin
					if (!enable) begin
						st_q <= upr_st_awake;
					end else if (is_se0) begin
						rst_resume <= 1'b1;
						st_q       <= upr_st_awake;
					end else if (is_k) begin
						resume <= 1'b1;
						st_q   <= upr_st_awake;
					end
				end
			endcase
		end
	end

	sequence s_susp_se0;
		suspended && enable && is_se0;
	endsequence

	sequence s_susp_k;
		suspended && enable && is_k;
	endsequence

	se0_resume_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_susp_se0 |=> rst_resume && !resume && !suspended)
		else $error("SE0 wake not flagged as reset");

	k_resume_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_susp_k |=> resume && !rst_resume && !suspended)
		else $error("K wake not flagged as resume");

	hw_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!enable |=> !suspended && !rst_resume && !resume)
		else $error("suspend logic active while disabled");

endmodule
`default_nettype wire
